// [rtl/tks_pkg.sv]
package tks_pkg;

  localparam logic [7:0] ADDR_KEY_LOW = 8'h03;
  localparam logic [7:0] ADDR_KEY_HIGH = 8'h04;
  localparam logic [7:0] ADDR_SLIDER = 8'h05;
  localparam logic [7:0] ADDR_PINS = 8'h06;
  localparam logic [7:0] ADDR_SUBREV = 8'h07;
  localparam logic [7:0] ADDR_RECAL = 8'h0A;
  localparam logic [7:0] ADDR_RESET = 8'h0B;
  localparam logic [7:0] ADDR_SLEEP = 8'h0C;
  localparam logic [7:0] ADDR_BURST = 8'h0D;
  localparam logic [7:0] ADDR_FALL = 8'h0F;
  localparam logic [7:0] ADDR_RISE = 8'h10;
  localparam logic [7:0] ADDR_INTEG = 8'h11;

  localparam logic [7:0] RST_SLEEP = 8'h01;
  localparam logic [5:0] RST_BURST = 6'h01;
  localparam logic [6:0] RST_FALL = 7'h14;
  localparam logic [6:0] RST_RISE = 7'h05;
  localparam logic [4:0] RST_INTEG = 5'h03;

  localparam int PIN_LSB = 2;
  localparam int HYST_COUNTS = 2;

  localparam int CLK_HZ = 40_000_000;
  localparam int CYCLE_MS = 16;
  localparam int CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;
  localparam int DRIFT_STEP_MS = 160;
  localparam int DRIFT_STEP_CLKS = CLK_HZ / 1000 * DRIFT_STEP_MS;

  typedef enum logic [1:0] {
    TKS_RUN = 2'b00,
    TKS_QUIESCE = 2'b01,
    TKS_RESTART = 2'b11
  } tks_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tks_req_t;

  typedef struct packed {
    logic [15:0] signal;
    logic [15:0] threshold;
  } tks_meas_t;

endpackage : tks_pkg

// [rtl/tks_core.sv]
`timescale 1ns/1ps

module tks_core
  import tks_pkg::*;
#(
  parameter int CYCLE_COUNT = CYCLE_CLKS,
  parameter int DRIFT_COUNT = DRIFT_STEP_CLKS,
  parameter logic [7:0] SUBREV = 8'h00 // Arbitrary value; replace per build
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire tks_req_t req_i,
  input wire tks_meas_t meas_i [16],
  input wire logic [15:0] key_enable_i,
  input wire logic [7:0] slider_pos_i,
  input wire logic slider_valid_i,
  input wire logic [2:0] pin_level_i,
  input wire logic [2:0] pin_is_output_i,
  output logic [7:0] rdata_o,
  output logic ack_o,
  output logic alert_n_o,
  output logic acquire_o,
  output logic [5:0] burst_repeat_o,
  output logic [15:0] recal_keys_o,
  output logic [15:0] ref_level_o [16]
);

  // Zero byte that command writes are compared against
  localparam logic [7:0] ZERO8 = 8'h00;

  logic [1:0] rsync_q;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  function automatic logic [15:0] sat_step(input logic [15:0] v, input logic up);
    if (up) begin
      sat_step = (v == 16'hFFFF) ? v : v + 16'h0001;
    end else begin
      sat_step = (v == 16'h0000) ? v : v - 16'h0001;
    end
  endfunction : sat_step

  // Settings
  logic [7:0] sleep_q, sleep_d;
  logic [5:0] burst_q, burst_d;
  logic [6:0] fall_q, fall_d;
  logic [6:0] rise_q, rise_d;
  logic [4:0] integ_q, integ_d;
  logic [7:0] recal_reg_q, recal_reg_d;
  logic [7:0] reset_reg_q, reset_reg_d;
  logic recal_pend_q, recal_pend_d;

  // Sequencer
  tks_state_t state_q, state_d;
  logic [31:0] tick_q, tick_d;
  logic [7:0] sleep_cnt_q, sleep_cnt_d;
  logic [31:0] drift_tmr_q, drift_tmr_d;
  logic [6:0] fall_cnt_q, fall_cnt_d;
  logic [6:0] rise_cnt_q, rise_cnt_d;
  logic acq;
  logic soft_rst;

  // Status
  logic [15:0] keys_q, keys_d;
  logic [7:0] slider_q, slider_d;
  logic [7:0] pins_q, pins_d;
  logic [3:0] dirty_q, dirty_d;
  logic [4:0] dicnt_q [16];
  logic [4:0] dicnt_d [16];
  logic [15:0] ref_q [16];
  logic [15:0] ref_d [16];
  logic [15:0] recal_keys_d;
  logic fall_step, rise_step;

  logic wr, rd;
  assign wr = req_i.valid && req_i.write && (state_q == TKS_RUN);
  assign rd = req_i.valid && !req_i.write && (state_q == TKS_RUN);

  // Register writes
  always_comb begin
    sleep_d = sleep_q;
    burst_d = burst_q;
    fall_d = fall_q;
    rise_d = rise_q;
    integ_d = integ_q;
    recal_reg_d = recal_reg_q;
    reset_reg_d = reset_reg_q;
    recal_pend_d = 1'b0;
    if (wr) begin
      if (req_i.addr == ADDR_RECAL) begin
        recal_reg_d = req_i.wdata;
        recal_pend_d = (req_i.wdata != ZERO8);
      end else if (req_i.addr == ADDR_RESET) begin
        reset_reg_d = req_i.wdata;
      end else if (req_i.addr == ADDR_SLEEP) begin
        sleep_d = req_i.wdata;
      end else if (req_i.addr == ADDR_BURST) begin
        burst_d = req_i.wdata[5:0];
      end else if (req_i.addr == ADDR_FALL) begin
        fall_d = req_i.wdata[6:0];
      end else if (req_i.addr == ADDR_RISE) begin
        rise_d = req_i.wdata[6:0];
      end else if (req_i.addr == ADDR_INTEG) begin
        integ_d = req_i.wdata[4:0];
      end
      // Status and sub-revision addresses take no write.
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sleep_q <= RST_SLEEP;
      burst_q <= RST_BURST;
      fall_q <= RST_FALL;
      rise_q <= RST_RISE;
      integ_q <= RST_INTEG;
      recal_reg_q <= 8'h00;
      reset_reg_q <= 8'h00;
      recal_pend_q <= 1'b0;
    end else if (soft_rst) begin
      sleep_q <= RST_SLEEP;
      burst_q <= RST_BURST;
      fall_q <= RST_FALL;
      rise_q <= RST_RISE;
      integ_q <= RST_INTEG;
      recal_reg_q <= 8'h00;
      reset_reg_q <= 8'h00;
      recal_pend_q <= 1'b0;
    end else if (clk_en_i) begin
      sleep_q <= sleep_d;
      burst_q <= burst_d;
      fall_q <= fall_d;
      rise_q <= rise_d;
      integ_q <= integ_d;
      recal_reg_q <= recal_reg_d;
      reset_reg_q <= reset_reg_d;
      recal_pend_q <= recal_pend_d;
    end
  end

  // Cycle timing and reset sequencing
  always_comb begin
    state_d = state_q;
    tick_d = tick_q + 32'd1;
    sleep_cnt_d = sleep_cnt_q;
    acq = 1'b0;
    soft_rst = 1'b0;
    if (tick_q >= 32'(CYCLE_COUNT - 1)) begin
      tick_d = 32'd0;
    end
    case (state_q)
      TKS_RUN: begin
        if (wr && req_i.addr == ADDR_RESET && req_i.wdata != ZERO8) begin
          state_d = TKS_QUIESCE;
          tick_d = 32'd0;
        end else if (tick_q >= 32'(CYCLE_COUNT - 1) && sleep_q != 8'h00) begin
          // One cycle boundary per 16 ms; acquire after sleep_q boundaries.
          if (sleep_cnt_q >= sleep_q - 8'h01) begin
            sleep_cnt_d = 8'h00;
            acq = 1'b1;
          end else begin
            sleep_cnt_d = sleep_cnt_q + 8'h01;
          end
        end
      end
      TKS_QUIESCE: begin
        // Acks and alert already withdrawn; wait one more cycle.
        if (tick_q >= 32'(CYCLE_COUNT - 1)) begin
          state_d = TKS_RESTART;
        end
      end
      TKS_RESTART: begin
        // Gated so a frozen clock enable cannot repeat the restore
        soft_rst = clk_en_i;
        state_d = TKS_RUN;
        tick_d = 32'd0;
        sleep_cnt_d = 8'h00;
      end
      default: begin
        state_d = TKS_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TKS_RUN;
      tick_q <= 32'd0;
      sleep_cnt_q <= 8'h00;
    end else if (clk_en_i) begin
      state_q <= state_d;
      tick_q <= tick_d;
      sleep_cnt_q <= sleep_cnt_d;
    end
  end

  // Drift rate prescalers; rates count in 0.16 s steps.
  always_comb begin
    drift_tmr_d = drift_tmr_q + 32'd1;
    fall_cnt_d = fall_cnt_q;
    rise_cnt_d = rise_cnt_q;
    fall_step = 1'b0;
    rise_step = 1'b0;
    if (drift_tmr_q >= 32'(DRIFT_COUNT - 1)) begin
      drift_tmr_d = 32'd0;
      // A count of zero is a pending step; it holds until taken
      if (fall_cnt_q != 7'h00) begin
        fall_cnt_d = (fall_cnt_q >= fall_q - 7'h01) ? 7'h00 : fall_cnt_q + 7'h01;
      end
      if (rise_cnt_q != 7'h00) begin
        rise_cnt_d = (rise_cnt_q >= rise_q - 7'h01) ? 7'h00 : rise_cnt_q + 7'h01;
      end
    end
    // A step is latched until the next acquisition consumes it.
    fall_step = (fall_q != 7'h00) && (fall_cnt_q == 7'h00);
    rise_step = (rise_q != 7'h00) && (rise_cnt_q == 7'h00);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      drift_tmr_q <= 32'd0;
      fall_cnt_q <= 7'h00;
      rise_cnt_q <= 7'h00;
    end else if (clk_en_i) begin
      drift_tmr_q <= drift_tmr_d;
      fall_cnt_q <= (acq && fall_step) ? 7'h01 : fall_cnt_d;
      rise_cnt_q <= (acq && rise_step) ? 7'h01 : rise_cnt_d;
    end
  end

  // Detection, drift and status bytes
  always_comb begin
    keys_d = keys_q;
    slider_d = slider_q;
    pins_d = pins_q;
    dirty_d = dirty_q;
    recal_keys_d = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      dicnt_d[k] = dicnt_q[k];
      ref_d[k] = ref_q[k];
    end
    if (recal_pend_q) begin
      for (int k = 0; k < 16; k++) begin
        if (key_enable_i[k]) begin
          ref_d[k] = meas_i[k].signal;
          dicnt_d[k] = 5'h00;
          keys_d[k] = 1'b0;
          recal_keys_d[k] = 1'b1;
        end
      end
    end else if (acq) begin
      for (int k = 0; k < 16; k++) begin
        if (!key_enable_i[k]) begin
          keys_d[k] = 1'b0;
          dicnt_d[k] = 5'h00;
        end else if (!keys_q[k]) begin
          if (meas_i[k].signal + meas_i[k].threshold <= ref_q[k]) begin
            if (dicnt_q[k] >= integ_q) begin
              keys_d[k] = 1'b1;
            end else begin
              dicnt_d[k] = dicnt_q[k] + 5'h01;
            end
          end else begin
            dicnt_d[k] = 5'h00;
            // Threshold is relative to ref, so it moves with it.
            if (meas_i[k].signal > ref_q[k] && rise_step) begin
              ref_d[k] = sat_step(ref_q[k], 1'b1);
            end else if (meas_i[k].signal < ref_q[k] && fall_step) begin
              ref_d[k] = sat_step(ref_q[k], 1'b0);
            end
          end
        end else if (meas_i[k].signal + meas_i[k].threshold
                     > ref_q[k] + 16'(HYST_COUNTS)) begin
          keys_d[k] = 1'b0;
          dicnt_d[k] = 5'h00;
        end
      end
      if (slider_valid_i) begin
        slider_d = slider_pos_i;
      end
      pins_d = 8'h00;
      pins_d[PIN_LSB +: 3] = pin_level_i & ~pin_is_output_i;
    end
    dirty_d[0] = dirty_q[0] | (keys_d[7:0] != keys_q[7:0]);
    dirty_d[1] = dirty_q[1] | (keys_d[15:8] != keys_q[15:8]);
    dirty_d[2] = dirty_q[2] | (slider_d != slider_q);
    dirty_d[3] = dirty_q[3] | (pins_d != pins_q);
    // A read clears only if no fresh change lands the same cycle.
    if (rd) begin
      if (req_i.addr == ADDR_KEY_LOW && keys_d[7:0] == keys_q[7:0]) begin
        dirty_d[0] = 1'b0;
      end else if (req_i.addr == ADDR_KEY_HIGH && keys_d[15:8] == keys_q[15:8]) begin
        dirty_d[1] = 1'b0;
      end else if (req_i.addr == ADDR_SLIDER && slider_d == slider_q) begin
        dirty_d[2] = 1'b0;
      end else if (req_i.addr == ADDR_PINS && pins_d == pins_q) begin
        dirty_d[3] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      keys_q <= 16'h0000;
      slider_q <= 8'h00;
      pins_q <= 8'h00;
      dirty_q <= 4'h0;
      recal_keys_o <= 16'h0000;
      for (int k = 0; k < 16; k++) begin
        dicnt_q[k] <= 5'h00;
        ref_q[k] <= 16'h0000;
      end
    end else if (soft_rst) begin
      keys_q <= 16'h0000;
      slider_q <= 8'h00;
      pins_q <= 8'h00;
      dirty_q <= 4'h0;
      recal_keys_o <= 16'hFFFF;
      for (int k = 0; k < 16; k++) begin
        dicnt_q[k] <= 5'h00;
        ref_q[k] <= meas_i[k].signal;
      end
    end else if (clk_en_i) begin
      keys_q <= keys_d;
      slider_q <= slider_d;
      pins_q <= pins_d;
      dirty_q <= dirty_d;
      recal_keys_o <= recal_keys_d;
      for (int k = 0; k < 16; k++) begin
        dicnt_q[k] <= dicnt_d[k];
        ref_q[k] <= ref_d[k];
      end
    end
  end

  // Read port and outputs
  logic [7:0] rdata_d;
  always_comb begin
    if (req_i.addr == ADDR_KEY_LOW) begin
      rdata_d = keys_q[7:0];
    end else if (req_i.addr == ADDR_KEY_HIGH) begin
      rdata_d = keys_q[15:8];
    end else if (req_i.addr == ADDR_SLIDER) begin
      rdata_d = slider_q;
    end else if (req_i.addr == ADDR_PINS) begin
      rdata_d = pins_q;
    end else if (req_i.addr == ADDR_SUBREV) begin
      rdata_d = SUBREV;
    end else if (req_i.addr == ADDR_RECAL) begin
      rdata_d = recal_reg_q;
    end else if (req_i.addr == ADDR_RESET) begin
      rdata_d = reset_reg_q;
    end else if (req_i.addr == ADDR_SLEEP) begin
      rdata_d = sleep_q;
    end else if (req_i.addr == ADDR_BURST) begin
      rdata_d = {2'b00, burst_q};
    end else if (req_i.addr == ADDR_FALL) begin
      rdata_d = {1'b0, fall_q};
    end else if (req_i.addr == ADDR_RISE) begin
      rdata_d = {1'b0, rise_q};
    end else if (req_i.addr == ADDR_INTEG) begin
      rdata_d = {3'b000, integ_q};
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
      ack_o <= 1'b0;
      alert_n_o <= 1'b1;
      acquire_o <= 1'b0;
      burst_repeat_o <= RST_BURST;
      for (int k = 0; k < 16; k++) begin
        ref_level_o[k] <= 16'h0000;
      end
    end else if (clk_en_i) begin
      rdata_o <= rd ? rdata_d : 8'h00;
      ack_o <= req_i.valid && (state_d == TKS_RUN) && (state_q == TKS_RUN);
      // Stale change flags must not raise the alert on the restore cycle
      alert_n_o <= !((|dirty_d) && state_d == TKS_RUN && !soft_rst);
      acquire_o <= acq;
      burst_repeat_o <= burst_q;
      for (int k = 0; k < 16; k++) begin
        ref_level_o[k] <= ref_d[k];
      end
    end
  end

endmodule : tks_core

// [dv/tks_monitor.sv]
`timescale 1ns/1ps

module tks_monitor
  import tks_pkg::*;
#(
  parameter logic [7:0] SUBREV = 8'h00
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire tks_req_t req_i,
  input wire logic [15:0] key_enable_i,
  input wire logic [7:0] rdata_o,
  input wire logic ack_o,
  input wire logic alert_n_o,
  input wire logic acquire_o,
  input wire logic [5:0] burst_repeat_o,
  input wire logic [15:0] recal_keys_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_ack_has_req: assert property (ack_o |-> $past(req_i.valid))
    else $error("ack without a request");
  chk_rdata_idle_zero: assert property (!$past(req_i.valid && !req_i.write) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  chk_pin_bits_zero: assert property (ack_o && $past(!req_i.write && req_i.addr == ADDR_PINS)
    |-> (rdata_o & 8'hE3) == 8'h00)
    else $error("pin byte has bits outside 2 to 4");
  chk_subrev_value: assert property (ack_o && $past(!req_i.write && req_i.addr == ADDR_SUBREV)
    |-> rdata_o == SUBREV)
    else $error("sub-revision byte wrong");
  chk_acq_spacing: assert property (acquire_o |=> (!acquire_o) [*8])
    else $error("acquisitions too close");
  chk_burst_follows: assert property ((req_i.valid && req_i.write && req_i.addr == ADDR_BURST)
    ##1 ack_o |=> burst_repeat_o == $past(req_i.wdata[5:0], 2))
    else $error("burst repeat output did not follow write");
  chk_alert_cause: assert property ($fell(alert_n_o)
    |-> acquire_o || $past(acquire_o) || $past(acquire_o, 2))
    else $error("alert raised away from an acquisition");
  chk_alert_release: assert property ($rose(alert_n_o)
    |-> $past(req_i.valid) || $past(req_i.valid, 2) || $past(req_i.valid, 3))
    else $error("alert released without host access");
  chk_reset_quiet: assert property ((req_i.valid && req_i.write && req_i.addr == ADDR_RESET
    && req_i.wdata != 8'h00) |-> ##3 (!ack_o && alert_n_o) [*8])
    else $error("bus or alert active after reset command");
  chk_recal_keys: assert property ((req_i.valid && req_i.write && req_i.addr == ADDR_RECAL
    && req_i.wdata != 8'h00) |-> ##[1:2] recal_keys_o == key_enable_i)
    else $error("recalibration did not hit enabled keys");

  cov_acquire: cover property (acquire_o);
  cov_alert: cover property ($fell(alert_n_o));
  cov_read: cover property (ack_o && $past(!req_i.write));
endmodule : tks_monitor

// [dv/tks_host_model.sv]
`timescale 1ns/1ps

module tks_host_model
  import tks_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  output tks_req_t req_o
);
  initial req_o = '0;

  // One byte per request; the pulse lasts one cycle, answer taken a cycle later
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rd, output logic got);
    logic [7:0] d;
    d = wdata;
    if (wr && addr == ADDR_BURST && d[5:0] == 6'h00) begin
      d = {2'b00, RST_BURST};
    end
    @(posedge ref_clk_i);
    #1;
    req_o = '{valid: 1'b1, write: wr, addr: addr, wdata: d};
    @(posedge ref_clk_i);
    #1;
    req_o = '0;
    got = ack_i;
    rd = rdata_i;
  endtask : access
endmodule : tks_host_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
  import tks_pkg::*;
  localparam int CYC = 40;
  localparam logic [15:0] SIG = 16'h03E8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  tks_req_t req;
  tks_meas_t meas [16];
  logic [7:0] slider_pos = 8'h00;
  logic slider_valid = 1'b0;
  logic [2:0] pin_lvl = 3'h0;
  logic [2:0] pin_out = 3'h0;
  logic [7:0] rdata;
  logic ack;
  logic alert_n;
  logic acq;
  logic [5:0] burst_repeat_count;
  logic [15:0] recal;
  logic [15:0] refs [16];
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] rd;
  logic got;

  always #12.5 clk = ~clk;

  // Short acquisition period keeps the run small; expectations scale from CYC
  tks_core #(.CYCLE_COUNT(CYC), .DRIFT_COUNT(400)) dut (
    .ref_clk_i(clk), .nrst_i(nrst), .clk_en_i(1'b1), .req_i(req), .meas_i(meas),
    .key_enable_i(16'hFFFF), .slider_pos_i(slider_pos), .slider_valid_i(slider_valid),
    .pin_level_i(pin_lvl), .pin_is_output_i(pin_out), .rdata_o(rdata), .ack_o(ack),
    .alert_n_o(alert_n), .acquire_o(acq), .burst_repeat_o(burst_repeat_count), .recal_keys_o(recal),
    .ref_level_o(refs)
  );
  tks_host_model host (.ref_clk_i(clk), .ack_i(ack), .rdata_i(rdata), .req_o(req));

  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, rd, got);
    `CHK("ack", 1'b1, got)
    `CHK("rdata", exp, rd)
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, rd, got);
  endtask : wr

  task automatic wait_acq;
    do begin
      @(posedge clk);
      #1;
    end while (acq !== 1'b1);
    repeat (3) @(posedge clk);
    #1;
  endtask : wait_acq

  task automatic t_defaults;
    rd_chk(ADDR_SLEEP, 8'h01);
    rd_chk(ADDR_BURST, 8'h01);
    rd_chk(ADDR_FALL, 8'h14);
    rd_chk(ADDR_RISE, 8'h05);
    rd_chk(ADDR_INTEG, 8'h03);
    `CHK("burst_repeat", 6'h01, burst_repeat_count)
  endtask : t_defaults

  task automatic t_readonly;
    for (int a = 3; a <= 7; a++) wr(8'(a), 8'hFF);
    rd_chk(ADDR_KEY_LOW, 8'h00);
    rd_chk(ADDR_SLIDER, 8'h00);
    rd_chk(ADDR_PINS, 8'h00);
    rd_chk(ADDR_SUBREV, 8'h00);
    rd_chk(8'h20, 8'h00);
  endtask : t_readonly

  task automatic t_detect;
    wr(ADDR_INTEG, 8'h01);
    wr(ADDR_RECAL, 8'h01);
    rd_chk(ADDR_RECAL, 8'h01);
    wait_acq();
    meas[9].signal = 16'h03D4;
    wait_acq();
    rd_chk(ADDR_KEY_HIGH, 8'h00);
    wait_acq();
    `CHK("alert_n", 1'b0, alert_n)
    rd_chk(ADDR_KEY_HIGH, 8'h02);
    rd_chk(ADDR_KEY_LOW, 8'h00);
    `CHK("alert_n", 1'b1, alert_n)
    `CHK("ref9", SIG, refs[9])
    // 1001 is inside the band kept by the fixed hysteresis, 1003 is outside it
    meas[9].signal = 16'h03DF;
    wait_acq();
    rd_chk(ADDR_KEY_HIGH, 8'h02);
    meas[9].signal = 16'h03E1;
    wait_acq();
    rd_chk(ADDR_KEY_HIGH, 8'h00);
    meas[9].signal = SIG;
  endtask : t_detect

  task automatic t_pins;
    wait_acq();
    pin_lvl = 3'h7;
    pin_out = 3'h2;
    slider_pos = 8'h5A;
    slider_valid = 1'b1;
    rd_chk(ADDR_PINS, 8'h00);
    wait_acq();
    slider_valid = 1'b0;
    rd_chk(ADDR_PINS, 8'h14);
    rd_chk(ADDR_SLIDER, 8'h5A);
    `CHK("alert_n", 1'b1, alert_n)
  endtask : t_pins

  task automatic t_sleep;
    int gap;
    wr(ADDR_SLEEP, 8'h00);
    repeat (2 * CYC) @(posedge clk);
    gap = 0;
    repeat (3 * CYC) begin
      @(posedge clk);
      #1;
      if (acq === 1'b1) gap++;
    end
    `CHK("acq_count", 0, gap)
    wr(ADDR_SLEEP, 8'h02);
    wait_acq();
    wait_acq();
    gap = 3;
    do begin
      @(posedge clk);
      #1;
      gap++;
    end while (acq !== 1'b1);
    `CHK("acq_gap", 2 * CYC, gap)
    wr(ADDR_SLEEP, 8'h01);
  endtask : t_sleep

  task automatic t_burst;
    wr(ADDR_BURST, 8'h3F);
    repeat (2) @(posedge clk);
    #1;
    `CHK("burst_repeat", 6'h3F, burst_repeat_count)
    rd_chk(ADDR_BURST, 8'h3F);
  endtask : t_burst

  task automatic t_softreset;
    wr(ADDR_FALL, 8'h7F);
    wr(ADDR_RESET, 8'h01);
    host.access(1'b0, ADDR_FALL, 8'h00, rd, got);
    `CHK("ack_quiesce", 1'b0, got)
    `CHK("alert_n", 1'b1, alert_n)
    repeat (4 * CYC) @(posedge clk);
    rd_chk(ADDR_FALL, 8'h14);
    rd_chk(ADDR_BURST, 8'h01);
  endtask : t_softreset

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    for (int k = 0; k < 16; k++) meas[k] = '{signal: SIG, threshold: 16'h000A};
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    t_defaults();
    t_readonly();
    t_detect();
    t_pins();
    t_sleep();
    t_burst();
    t_softreset();
    report_and_stop();
  end
endmodule : tb_top

bind tks_core tks_monitor #(.SUBREV(SUBREV)) u_mon (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req_i), .key_enable_i(key_enable_i),
  .rdata_o(rdata_o), .ack_o(ack_o), .alert_n_o(alert_n_o), .acquire_o(acquire_o),
  .burst_repeat_o(burst_repeat_o), .recal_keys_o(recal_keys_o)
);
